// ===== pkg/nfc_pkg.sv
// Package of register offsets, fields and reset values for the flash regs
package nfc_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] NFC_OFS_CONTROL = 32'h2002_0010;
  localparam logic [31:0] NFC_OFS_CONFIG = 32'h2002_0014;
  localparam logic [31:0] NFC_OFS_STATUS = 32'h2002_0018;
  localparam logic [31:0] NFC_OFS_INT_STAT = 32'h2002_001c;
  localparam logic [31:0] NFC_OFS_INT_MASK = 32'h2002_0020;
  localparam logic [31:0] NFC_OFS_INT_SET = 32'h2002_0024;
  localparam logic [31:0] NFC_OFS_INT_CLR = 32'h2002_0028;
  // ==========================================================
  // Control fields
  localparam int NFC_CTL_DMA_START = 0;
  localparam int NFC_CTL_ECC_CLEAR = 1;
  localparam int NFC_CTL_SOFT_RESET = 2;
  // ==========================================================
  // Configuration fields
  localparam int NFC_CFG_WIDTH = 0;
  localparam int NFC_CFG_DMA_DIR = 1;
  localparam int NFC_CFG_DMA_BURST = 2;
  localparam int NFC_CFG_ECC_EN = 3;
  localparam int NFC_CFG_DMA_ECC = 4;
  localparam int NFC_CFG_CE_LOW = 5;
  localparam int NFC_CFG_BITS = 6;
  localparam logic [5:0] NFC_CFG_RESET = 6'h00;
  // ==========================================================
  // Status and interrupt fields
  localparam int NFC_ST_READY = 0;
  localparam int NFC_ST_CMD_FIFO = 1;
  localparam int NFC_ST_DMA_FIFO = 2;
  localparam int NFC_INT_RDY = 0;
  localparam int NFC_INT_COUNT = 1;
  localparam logic [1:0] NFC_INT_RESET = 2'h0;
  // ==========================================================
  // Data FIFO level for burst requests, FIFO count width
  localparam logic [4:0] NFC_BURST_WORDS = 5'h04;
  localparam int NFC_LVL_W = 5;
endpackage : nfc_pkg

// ===== verilog/nfc_sync2.sv
// Two flip-flop synchroniser for one level input
`timescale 1ns/100ps
module nfc_sync2
  import nfc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta;
  logic next_meta;
  logic next_sync;

  // Shift the level along the chain
  always_comb
  begin
    next_meta = async_i;
    next_sync = meta;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule : nfc_sync2

// ===== verilog/nfc_regs.sv
// Control, configuration, status and interrupt registers of the flash ctrl
`timescale 1ns/100ps
// Behaviour
// - Writing one to control bit 2 resets the whole controller; self-clearing.
// - Writing one to control bit 1 clears ECC parity and its counter.
// - Writing one to control bit 0 starts the DMA data channel.
// - Config bit 5 forces chip enable low; else low only while accessing.
// - Config bit 3 enables ECC; config bit 4 enables DMA ECC channel.
// - Config bit 2 zero: single request zero only; one: burst request.
// - Config bit 1 sets DMA direction: zero write to, one read from.
// - Status bit 2 is one while the DMA data FIFO holds data.
// - Status bit 1 is one while the command/address queue is nonempty.
// - Status bit 0 follows the flash ready input; one means ready.
// - Interrupt status bit 1 is terminal-count flag masked by its enable.
// - Interrupt status bit 0 is ready flag masked by its enable.
// - Status and interrupt status registers are read-only.
// - Count flag sets when counter reaches zero; ready flag on ready rise.
// - Burst request: reading with four or more words, writing fewer.
module nfc_regs
  import nfc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic bus_sel_i,
  input wire logic bus_write_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  input wire logic flash_ready_i,
  input wire logic flash_access_i,
  input wire logic [4:0] data_fifo_level_i,
  input wire logic cmd_fifo_nonempty_i,
  input wire logic transfer_counter_zero_i,
  input wire logic dma_clear_i,
  output logic soft_reset_trigger_o,
  output logic ecc_clear_o,
  output logic dma_start_o,
  output logic ecc_enable_o,
  output logic dma_ecc_enable_o,
  output logic dma_read_o,
  output logic wide_device_o,
  output logic chip_enable_n_o,
  output logic single_request_zero_o,
  output logic burst_request_o,
  output logic irq_o
);
  // ==========================================================
  // State
  logic [5:0] cfg;
  logic [5:0] next_cfg;
  logic [1:0] int_flag;
  logic [1:0] next_int_flag;
  logic [1:0] interrupt_mask_reg;
  logic [1:0] next_interrupt_mask_reg;
  logic [2:0] ctl_pulse;
  logic [2:0] next_ctl_pulse;
  logic [31:0] next_rdata;
  logic chan_active;
  logic next_chan_active;
  logic req;
  logic next_req;
  logic rdy_prev;
  logic next_rdy_prev;
  logic cnt_zero_prev;
  logic next_cnt_zero_prev;
  logic rdy_sync;
  logic [1:0] masked;
  logic wr;
  logic [2:0] ctl_bits;
  logic want_req;

  // Ready pin passes two flops before any logic reads it
  nfc_sync2 u_rdy_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .async_i(flash_ready_i),
    .sync_o(rdy_sync)
  );

  assign wr = bus_sel_i && bus_write_i;
  assign masked = int_flag & interrupt_mask_reg;
  assign ctl_bits = bus_wdata_i[2:0];

  // ==========================================================
  // Next values of registers, flags and strobes
  always_comb
  begin
    next_cfg = cfg;
    next_interrupt_mask_reg = interrupt_mask_reg;
    next_int_flag = int_flag;
    next_ctl_pulse = 3'h0;
    next_rdy_prev = rdy_sync;
    next_cnt_zero_prev = transfer_counter_zero_i;
    next_chan_active = chan_active;
    next_req = req;
    if (wr && bus_addr_i == NFC_OFS_CONTROL)
    begin
      next_ctl_pulse = ctl_bits;
    end
    if (wr && bus_addr_i == NFC_OFS_CONFIG)
    begin
      next_cfg = bus_wdata_i[5:0];
    end
    if (wr && bus_addr_i == NFC_OFS_INT_MASK)
    begin
      next_interrupt_mask_reg = bus_wdata_i[1:0];
    end
    // Clear first so that a set in the same cycle wins
    if (wr && bus_addr_i == NFC_OFS_INT_CLR)
    begin
      next_int_flag = next_int_flag & ~bus_wdata_i[1:0];
    end
    if (wr && bus_addr_i == NFC_OFS_INT_SET)
    begin
      next_int_flag = next_int_flag | bus_wdata_i[1:0];
    end
    if (transfer_counter_zero_i && !cnt_zero_prev)
    begin
      next_int_flag[NFC_INT_COUNT] = 1'b1;
    end
    if (rdy_sync && !rdy_prev)
    begin
      next_int_flag[NFC_INT_RDY] = 1'b1;
    end
    // Data channel runs from start until the transfer count hits zero
    if (ctl_pulse[NFC_CTL_DMA_START])
    begin
      next_chan_active = 1'b1;
    end
    else if (transfer_counter_zero_i && !cnt_zero_prev)
    begin
      next_chan_active = 1'b0;
    end
    // Request raised on the wanted level, held until the DMA clears it or the channel stops
    if (dma_clear_i || !chan_active)
    begin
      next_req = 1'b0;
    end
    else if (want_req)
    begin
      next_req = 1'b1;
    end
    // Soft reset returns the register state to its reset values
    if (ctl_pulse[NFC_CTL_SOFT_RESET])
    begin
      next_cfg = NFC_CFG_RESET;
      next_interrupt_mask_reg = NFC_INT_RESET;
      next_int_flag = NFC_INT_RESET;
      next_chan_active = 1'b0;
      next_req = 1'b0;
    end
  end

  // Level condition for a data request in the chosen direction
  always_comb
  begin
    if (!cfg[NFC_CFG_DMA_BURST])
    begin
      want_req = 1'b1;
    end
    else if (cfg[NFC_CFG_DMA_DIR])
    begin
      want_req = data_fifo_level_i >= NFC_BURST_WORDS;
    end
    else
    begin
      want_req = data_fifo_level_i < NFC_BURST_WORDS;
    end
  end

  // Read data multiplexer; reserved bits and unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (bus_addr_i)
      NFC_OFS_CONTROL: next_rdata = 32'h0000_0000;
      NFC_OFS_CONFIG: next_rdata = {26'h0, cfg};
      NFC_OFS_STATUS:
        next_rdata = {29'h0, data_fifo_level_i != 5'h00,
          cmd_fifo_nonempty_i, rdy_sync};
      NFC_OFS_INT_STAT: next_rdata = {30'h0, masked};
      NFC_OFS_INT_MASK: next_rdata = {30'h0, interrupt_mask_reg};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg <= NFC_CFG_RESET;
      interrupt_mask_reg <= NFC_INT_RESET;
      int_flag <= NFC_INT_RESET;
      ctl_pulse <= 3'h0;
      rdy_prev <= 1'b0;
      cnt_zero_prev <= 1'b0;
      chan_active <= 1'b0;
      req <= 1'b0;
      bus_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      cfg <= next_cfg;
      interrupt_mask_reg <= next_interrupt_mask_reg;
      int_flag <= next_int_flag;
      ctl_pulse <= next_ctl_pulse;
      rdy_prev <= next_rdy_prev;
      cnt_zero_prev <= next_cnt_zero_prev;
      chan_active <= next_chan_active;
      req <= next_req;
      bus_rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // Outputs
  assign soft_reset_trigger_o = ctl_pulse[NFC_CTL_SOFT_RESET];
  assign ecc_clear_o = ctl_pulse[NFC_CTL_ECC_CLEAR];
  assign dma_start_o = ctl_pulse[NFC_CTL_DMA_START];
  assign ecc_enable_o = cfg[NFC_CFG_ECC_EN];
  assign dma_ecc_enable_o = cfg[NFC_CFG_DMA_ECC];
  assign dma_read_o = cfg[NFC_CFG_DMA_DIR];
  assign wide_device_o = cfg[NFC_CFG_WIDTH];
  // Chip enable low when forced, else only during flash access
  assign chip_enable_n_o = !(cfg[NFC_CFG_CE_LOW] || flash_access_i);
  assign single_request_zero_o = req && !cfg[NFC_CFG_DMA_BURST];
  assign burst_request_o = req && cfg[NFC_CFG_DMA_BURST];
  assign irq_o = |masked;

  // ==========================================================
  // Assertions
  a_ctl_self_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr && bus_addr_i == NFC_OFS_CONTROL && bus_wdata_i[2])
    |=> soft_reset_trigger_o ##1 !soft_reset_trigger_o || $past(wr))
    else $error("soft reset strobe not one cycle");
  a_ecc_clear_pulse: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr && bus_addr_i == NFC_OFS_CONTROL && bus_wdata_i[1]) |=> ecc_clear_o)
    else $error("ecc clear missing");
  a_dma_start_go: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    dma_start_o |=> chan_active)
    else $error("channel not started");
  a_chip_en_force: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cfg[NFC_CFG_CE_LOW] |-> !chip_enable_n_o)
    else $error("chip enable not forced low");
  a_cfg_written: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr && bus_addr_i == NFC_OFS_CONFIG && !soft_reset_trigger_o)
    |=> ecc_enable_o == $past(bus_wdata_i[3])
      && dma_read_o == $past(bus_wdata_i[1]))
    else $error("config not stored");
  a_req_single: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !cfg[NFC_CFG_DMA_BURST] |-> !burst_request_o)
    else $error("burst request in single mode");
  a_burst_level: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (burst_request_o && $rose(req) && dma_read_o)
    |-> $past(data_fifo_level_i) >= NFC_BURST_WORDS)
    else $error("burst raised below level");
  a_ready_status: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_sel_i && !bus_write_i && bus_addr_i == NFC_OFS_STATUS)
    |=> bus_rdata_o[NFC_ST_READY] == $past(rdy_sync))
    else $error("ready status wrong");
  a_count_flag_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ($rose(transfer_counter_zero_i) && !soft_reset_trigger_o)
    |=> int_flag[NFC_INT_COUNT])
    else $error("count flag not set");
  a_ready_flag_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ($rose(rdy_sync) && !soft_reset_trigger_o)
    |=> int_flag[NFC_INT_RDY])
    else $error("ready flag not set");
  a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr && bus_addr_i == NFC_OFS_INT_MASK && bus_wdata_i[1:0] == 2'h0)
    |=> !irq_o)
    else $error("interrupt output not masked");
  a_stat_readonly: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr && bus_addr_i == NFC_OFS_INT_STAT && !soft_reset_trigger_o
      && !$rose(transfer_counter_zero_i) && !$rose(rdy_sync))
    |=> int_flag == $past(int_flag))
    else $error("status write had effect");
  a_fifo_status: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_sel_i && !bus_write_i && bus_addr_i == NFC_OFS_STATUS)
    |=> bus_rdata_o[NFC_ST_DMA_FIFO] == ($past(data_fifo_level_i) != 5'h00)
      && bus_rdata_o[NFC_ST_CMD_FIFO] == $past(cmd_fifo_nonempty_i))
    else $error("fifo status wrong");
  a_chan_end_drop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ($rose(transfer_counter_zero_i) && !dma_start_o)
    |-> ##2 !(single_request_zero_o || burst_request_o))
    else $error("request kept after count end");

  c_burst_req: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(burst_request_o));
  c_single_req: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(single_request_zero_o));
  c_irq_rise: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(irq_o));
  c_soft_reset: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    soft_reset_trigger_o);
  c_chan_end: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $fell(chan_active));
endmodule : nfc_regs

// ===== verif/nfc_dma_model.sv
// DMA controller model that answers requests with a clear pulse
`timescale 1ns/100ps
module nfc_dma_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic slow_i,
  output logic dma_clear_o
);
  int cnt;
  // ==========================================================
  // Wait 1 or 4 cycles after a request, then pulse clear once
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt <= 0;
      dma_clear_o <= 1'b0;
    end
    else
    begin
      dma_clear_o <= 1'b0;
      if (!req_i || dma_clear_o)
        cnt <= 0;
      else if (cnt == (slow_i ? 4 : 1))
        dma_clear_o <= 1'b1;
      else
        cnt <= cnt + 1;
    end
  end
endmodule : nfc_dma_model

// ===== verif/nfc_regs_tb_top.sv
// Self-checking bench for the flash register bank
`timescale 1ns/100ps
module nfc_regs_tb_top;
  import nfc_pkg::*;
  logic clk_sys_i = 0, nrst_i = 0, sel = 0, wr = 0, rdy = 0, acc = 0;
  logic cmdne = 0, tcz = 0, clr, slow = 0, srst, eclr, dst, ecc_en;
  logic decc, drd, wide, chip_en_n, sreq, breq, irq;
  logic [31:0] addr = 32'h0, wd = 32'h0, rd, tmp;
  logic [4:0] lvl = 5'h00;
  int fail_count = 0, n_checks = 0, cyc = 0;
  // ==========================================================
  // Design and DMA partner
  nfc_regs dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .bus_sel_i(sel), .bus_write_i(wr), .bus_addr_i(addr),
    .bus_wdata_i(wd), .bus_rdata_o(rd), .flash_ready_i(rdy),
    .flash_access_i(acc), .data_fifo_level_i(lvl),
    .cmd_fifo_nonempty_i(cmdne), .transfer_counter_zero_i(tcz),
    .dma_clear_i(clr), .soft_reset_trigger_o(srst), .ecc_clear_o(eclr),
    .dma_start_o(dst), .ecc_enable_o(ecc_en), .dma_ecc_enable_o(decc),
    .dma_read_o(drd), .wide_device_o(wide), .chip_enable_n_o(chip_en_n),
    .single_request_zero_o(sreq), .burst_request_o(breq), .irq_o(irq));
  nfc_dma_model dma_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .req_i(sreq | breq), .slow_i(slow), .dma_clear_o(clr));
  // Clock and hang guard
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wcyc
  // One single-cycle access; read data is taken one cycle later
  task automatic bus(input logic w, input logic [31:0] a, d);
    wcyc(1);
    sel = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    wcyc(1);
    tmp = rd;
    sel = 1'b0;
    wr = 1'b0;
  endtask : bus
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(tmp, exp);
  endtask : rdc
  // Start the channel, wait a bounded time for a request, then end it
  task automatic dma_run(input logic [1:0] exp);
    bus(1'b1, NFC_OFS_CONTROL, 32'h1);
    for (int i = 0; i < 8 && {sreq, breq} !== exp; i++)
      wcyc(1);
    chk({sreq, breq}, exp);
    tcz = 1'b1;
    wcyc(3);
    chk({sreq, breq}, 32'h0);
    tcz = 1'b0;
  endtask : dma_run
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdc(NFC_OFS_CONTROL, 32'h0);
    rdc(NFC_OFS_CONFIG, 32'h0);
    rdc(NFC_OFS_INT_STAT, 32'h0);
    chk({irq, sreq, breq}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ctrl;
    bus(1'b1, NFC_OFS_CONFIG, 32'h08);
    for (int b = 0; b < 3; b++)
    begin
      bus(1'b1, NFC_OFS_CONTROL, 32'h1 << b);
      chk({srst, eclr, dst}, 32'h1 << b);
      wcyc(1);
      chk({srst, eclr, dst}, 32'h0);
    end
    wcyc(2);
    rdc(NFC_OFS_CONFIG, 32'h0);
    bus(1'b1, NFC_OFS_CONTROL, 32'h0);
    chk({srst, eclr, dst, ecc_en}, 32'h0);
    $display("test control done");
  endtask : t_ctrl
  task automatic t_cfg;
    bus(1'b1, NFC_OFS_CONFIG, 32'h3a);
    rdc(NFC_OFS_CONFIG, 32'h3a);
    chk({ecc_en, decc, drd, wide, chip_en_n}, 32'h1c);
    bus(1'b1, NFC_OFS_CONFIG, 32'h0);
    wcyc(1);
    chk({ecc_en, decc, drd, chip_en_n}, 32'h1);
    acc = 1'b1;
    wcyc(1);
    chk(chip_en_n, 32'h0);
    acc = 1'b0;
    wcyc(1);
    chk(chip_en_n, 32'h1);
    $display("test config done");
  endtask : t_cfg
  task automatic t_stat;
    lvl = 5'h01;
    cmdne = 1'b1;
    rdy = 1'b1;
    wcyc(4);
    rdc(NFC_OFS_STATUS, 32'h7);
    lvl = 5'h00;
    cmdne = 1'b0;
    rdy = 1'b0;
    wcyc(4);
    bus(1'b1, NFC_OFS_STATUS, 32'h7);
    rdc(NFC_OFS_STATUS, 32'h0);
    $display("test status done");
  endtask : t_stat
  task automatic t_irq;
    bus(1'b1, NFC_OFS_INT_CLR, 32'h3);
    bus(1'b1, NFC_OFS_INT_MASK, 32'h3);
    rdc(NFC_OFS_INT_STAT, 32'h0);
    tcz = 1'b1;
    wcyc(3);
    rdc(NFC_OFS_INT_STAT, 32'h2);
    chk(irq, 32'h1);
    bus(1'b1, NFC_OFS_INT_MASK, 32'h1);
    rdc(NFC_OFS_INT_STAT, 32'h0);
    chk(irq, 32'h0);
    rdy = 1'b1;
    wcyc(4);
    rdc(NFC_OFS_INT_STAT, 32'h1);
    bus(1'b1, NFC_OFS_INT_STAT, 32'h0);
    rdc(NFC_OFS_INT_STAT, 32'h1);
    bus(1'b1, NFC_OFS_INT_CLR, 32'h3);
    rdc(NFC_OFS_INT_STAT, 32'h0);
    bus(1'b1, NFC_OFS_INT_SET, 32'h3);
    rdc(NFC_OFS_INT_STAT, 32'h1);
    chk(irq, 32'h1);
    bus(1'b1, NFC_OFS_INT_MASK, 32'h3);
    rdc(NFC_OFS_INT_STAT, 32'h3);
    bus(1'b1, NFC_OFS_INT_MASK, 32'h0);
    chk(irq, 32'h0);
    bus(1'b1, NFC_OFS_INT_CLR, 32'h3);
    tcz = 1'b0;
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_dma;
    slow = 1'b1;
    dma_run(2'b10);
    slow = 1'b0;
    lvl = 5'h05;
    bus(1'b1, NFC_OFS_CONFIG, 32'h06);
    dma_run(2'b01);
    bus(1'b1, NFC_OFS_CONFIG, 32'h04);
    bus(1'b1, NFC_OFS_CONTROL, 32'h1);
    wcyc(4);
    chk({sreq, breq}, 32'h0);
    tcz = 1'b1;
    wcyc(3);
    tcz = 1'b0;
    lvl = 5'h03;
    dma_run(2'b01);
    $display("test dma done");
  endtask : t_dma
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    nrst_i = 1'b1;
    t_reset();
    t_ctrl();
    t_cfg();
    t_stat();
    t_irq();
    t_dma();
    conclude();
  end
endmodule : nfc_regs_tb_top
